// ===== hdl/gpcfg_pkg.sv
/*
  constants of the pin-2 configuration and input-level block: register
  offsets, field positions, reset values, source codes and serial-port framing.
  assumes the block sits behind a two-wire serial configuration port.
*/
// Summary of operation
// - Bits 7:4 pick the pin-2 source: 0000 output data bit two, 0001 free clock, 0010 link clock, 0011 recovered clock, others reserved.
// - Bits 3:2 set the resistors: 00 none, 01 pull-down, 10 pull-up, 11 reserved, reset 01.
// - Bit 1 enables the pin-2 input buffer when set and resets to 0.
// - Reading the input-level register at offset 05 returns the level on each pin used as an input.
// - Pin 2's level sits in bit 2 of the input-level register and bits 7:3 are reserved.
// - Pins 0 and 1 report their levels in bits 0 and 1 of the input-level register, read-only.
package gpcfg_pkg;
  localparam logic [7:0] GPCFG_OFS_CFG = 8'h04;
  localparam logic [7:0] GPCFG_OFS_LVL = 8'h05;
  localparam logic [7:0] GPCFG_CFG_RST = 8'h05;
  localparam int GPCFG_SRC_HI = 7;
  localparam int GPCFG_SRC_LO = 4;
  localparam int GPCFG_RES_HI = 3;
  localparam int GPCFG_RES_LO = 2;
  localparam int GPCFG_INBUF_BIT = 1;
  localparam int GPCFG_DRV_BIT = 0;
  localparam logic [3:0] GPCFG_SRC_DATA = 4'h0;
  localparam logic [3:0] GPCFG_SRC_FREECLK = 4'h1;
  localparam logic [3:0] GPCFG_SRC_LINKCLK = 4'h2;
  localparam logic [3:0] GPCFG_SRC_RECCLK = 4'h3;
  localparam logic [1:0] GPCFG_RES_NONE = 2'h0;
  localparam logic [1:0] GPCFG_RES_DOWN = 2'h1;
  localparam logic [1:0] GPCFG_RES_UP = 2'h2;
  localparam logic [6:0] GPCFG_DEF_ADDR = 7'h5a;
  localparam logic [3:0] GPCFG_BYTE_BITS = 4'h8;
  localparam int GPCFG_SYNC_W = 5;
  typedef enum logic [3:0] {
    GPCFG_IDLE, GPCFG_ADDR, GPCFG_ADDR_ACK, GPCFG_REG, GPCFG_REG_ACK,
    GPCFG_WDATA, GPCFG_WDATA_ACK, GPCFG_RDATA, GPCFG_RDATA_ACK
  } gpcfg_state_t;
endpackage

// ===== hdl/gpcfg_sync_if.sv
/*
  carrier of the filtered pin levels from the synchroniser to the block.
  assumes one clock for both ends.
*/
interface gpcfg_sync_if #(
  parameter int W = 5
);
  logic [W-1:0] level;
  modport src (output level);
  modport dst (input level);
endinterface

// ===== hdl/gpcfg_pin_sync.sv
/*
  three-stage synchroniser with agreement filter for asynchronous pins.
  assumes raw inputs may change at any time relative to clk.
*/
module gpcfg_pin_sync #(
  parameter int W = 5,
  parameter logic [W-1:0] RST_VAL = '1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins
  input wire logic [W-1:0] raw,
  // filtered levels
  gpcfg_sync_if.src lvl
);
  logic [W-1:0] s1_r, s2_r, s3_r, lvl_r;
  logic [W-1:0] lvl_nxt;

  if (W < 1) begin : g_chk
    $error("gpcfg_pin_sync: width must be at least one");
  end

  // a level is taken only once the second and third stages agree
  always_comb begin
    for (int i = 0; i < W; i++) begin
      lvl_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : lvl_r[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      lvl_r <= RST_VAL;
    end else begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      lvl_r <= lvl_nxt;
    end
  end

  assign lvl.level = lvl_r;
endmodule // gpcfg_pin_sync

// ===== hdl/gpcfg_top.sv
/*
  pin-2 configuration register, input-level register and the two-wire
  serial configuration slave that reaches them.
  assumes scl and sda come from board pins, sda is open-drain pulled up
  outside, and the clock sources for pin 2 are plain inputs sampled here.
*/
module gpcfg_top
  import gpcfg_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = gpcfg_pkg::GPCFG_DEF_ADDR
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial configuration port
  input wire logic scl,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // pin-2 sources
  input wire logic output_data_bit_two,
  input wire logic free_clk_in,
  input wire logic link_tx_clk_in,
  input wire logic rec_clk_in,
  // levels on the three general-purpose pins
  input wire logic [2:0] gp_pin_in,
  // pin-2 pad control
  output logic gp2_out,
  output logic pin_driver_on,
  output logic gp2_in_buf_en,
  output logic gp2_pull_down,
  output logic gp2_pull_up
);
  import gpcfg_pkg::*;

  if (SLAVE_ADDR == 7'h00) begin : g_chk
    $error("gpcfg_top: address 0 is the general call and cannot be used");
  end

  gpcfg_sync_if #(.W(GPCFG_SYNC_W)) sync_if ();

  gpcfg_pin_sync #(.W(GPCFG_SYNC_W), .RST_VAL(5'h1f)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .raw({gp_pin_in, sda_i, scl}),
    .lvl(sync_if.src)
  );

  logic scl_f, sda_f;
  logic [2:0] pin_f;
  assign scl_f = sync_if.level[0];
  assign sda_f = sync_if.level[1];
  assign pin_f = sync_if.level[4:2];

  // edge and condition detection
  logic scl_q_r, sda_q_r;
  logic scl_rise, scl_fall, start_c, stop_c;
  assign scl_rise = scl_f & ~scl_q_r;
  assign scl_fall = ~scl_f & scl_q_r;
  assign start_c = scl_f & scl_q_r & sda_q_r & ~sda_f;
  assign stop_c = scl_f & scl_q_r & ~sda_q_r & sda_f;

  // slave state
  gpcfg_state_t st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [7:0] ptr_r, ptr_nxt;
  logic rw_r, rw_nxt;
  logic sda_oe_r, sda_oe_nxt;
  logic [7:0] cfg_r, cfg_nxt;

  function automatic logic [7:0] read_value(input logic [7:0] ofs, input logic [7:0] cfg,
                                            input logic [2:0] pins);
    if (ofs == GPCFG_OFS_CFG) begin
      read_value = cfg;
    end else if (ofs == GPCFG_OFS_LVL) begin
      // pin 2 reads zero while its input buffer is off
      read_value = {5'h00, pins[2] & cfg[GPCFG_INBUF_BIT], pins[1], pins[0]};
    end else begin
      read_value = 8'h00;
    end
  endfunction

  // a function result cannot be bit-selected, so the read byte gets a name of its own
  logic [7:0] rd_val;
  assign rd_val = read_value(ptr_r, cfg_r, pin_f);

  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    cnt_nxt = cnt_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    sda_oe_nxt = sda_oe_r;
    cfg_nxt = cfg_r;
    if (stop_c) begin
      st_nxt = GPCFG_IDLE;
      sda_oe_nxt = 1'b0;
    end else if (start_c) begin
      st_nxt = GPCFG_ADDR;
      cnt_nxt = 4'h0;
      sda_oe_nxt = 1'b0;
    end else begin
      unique case (st_r)
        GPCFG_IDLE: begin
        end
        GPCFG_ADDR, GPCFG_REG, GPCFG_WDATA: begin
          if (scl_rise) begin
            sh_nxt = {sh_r[6:0], sda_f};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == GPCFG_BYTE_BITS) begin
            cnt_nxt = 4'h0;
            sda_oe_nxt = 1'b1;
            if (st_r == GPCFG_ADDR) begin
              if (sh_r[7:1] == SLAVE_ADDR) begin
                rw_nxt = sh_r[0];
                st_nxt = GPCFG_ADDR_ACK;
              end else begin
                sda_oe_nxt = 1'b0;
                st_nxt = GPCFG_IDLE;
              end
            end else if (st_r == GPCFG_REG) begin
              ptr_nxt = sh_r;
              st_nxt = GPCFG_REG_ACK;
            end else begin
              // the level register and unmapped offsets swallow writes
              if (ptr_r == GPCFG_OFS_CFG) begin
                cfg_nxt = sh_r;
              end
              st_nxt = GPCFG_WDATA_ACK;
            end
          end
        end
        GPCFG_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              sh_nxt = rd_val;
              sda_oe_nxt = ~rd_val[7];
              st_nxt = GPCFG_RDATA;
            end else begin
              sda_oe_nxt = 1'b0;
              st_nxt = GPCFG_REG;
            end
          end
        end
        GPCFG_REG_ACK, GPCFG_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe_nxt = 1'b0;
            st_nxt = GPCFG_WDATA;
          end
        end
        GPCFG_RDATA: begin
          if (scl_fall) begin
            if (cnt_r == GPCFG_BYTE_BITS - 4'h1) begin
              cnt_nxt = 4'h0;
              sda_oe_nxt = 1'b0;
              st_nxt = GPCFG_RDATA_ACK;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              sda_oe_nxt = ~sh_r[6];
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        GPCFG_RDATA_ACK: begin
          // a not-acknowledge ends the read; the master then stops
          if (scl_rise && sda_f) begin
            st_nxt = GPCFG_IDLE;
          end else if (scl_fall) begin
            sh_nxt = rd_val;
            sda_oe_nxt = ~rd_val[7];
            st_nxt = GPCFG_RDATA;
          end
        end
        default: begin
          st_nxt = GPCFG_IDLE;
          sda_oe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
      st_r <= GPCFG_IDLE;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      sda_oe_r <= 1'b0;
      cfg_r <= GPCFG_CFG_RST;
    end else begin
      scl_q_r <= scl_f;
      sda_q_r <= sda_f;
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      cnt_r <= cnt_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      sda_oe_r <= sda_oe_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // pad control; clock sources are resampled, so they come out with one cycle of delay
  logic gp2_out_r, gp2_out_nxt, drv_r, drv_nxt, ibuf_r, ibuf_nxt, pd_r, pd_nxt, pu_r, pu_nxt;

  always_comb begin
    unique case (cfg_r[GPCFG_SRC_HI:GPCFG_SRC_LO])
      GPCFG_SRC_DATA: gp2_out_nxt = output_data_bit_two;
      GPCFG_SRC_FREECLK: gp2_out_nxt = free_clk_in;
      GPCFG_SRC_LINKCLK: gp2_out_nxt = link_tx_clk_in;
      GPCFG_SRC_RECCLK: gp2_out_nxt = rec_clk_in;
      default: gp2_out_nxt = 1'b0;
    endcase
    drv_nxt = cfg_r[GPCFG_DRV_BIT];
    ibuf_nxt = cfg_r[GPCFG_INBUF_BIT];
    // reserved resistor code leaves both resistors off
    pd_nxt = cfg_r[GPCFG_RES_HI:GPCFG_RES_LO] == GPCFG_RES_DOWN;
    pu_nxt = cfg_r[GPCFG_RES_HI:GPCFG_RES_LO] == GPCFG_RES_UP;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gp2_out_r <= 1'b0;
      drv_r <= 1'b1;
      ibuf_r <= 1'b0;
      pd_r <= 1'b1;
      pu_r <= 1'b0;
    end else begin
      gp2_out_r <= gp2_out_nxt;
      drv_r <= drv_nxt;
      ibuf_r <= ibuf_nxt;
      pd_r <= pd_nxt;
      pu_r <= pu_nxt;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = sda_oe_r;
  assign gp2_out = gp2_out_r;
  assign pin_driver_on = drv_r;
  assign gp2_in_buf_en = ibuf_r;
  assign gp2_pull_down = pd_r;
  assign gp2_pull_up = pu_r;
endmodule // gpcfg_top

// ===== tb/gpcfg_assertions.sv
/*
  port checker for the pin-2 configuration block.
  assumes one clock and binding onto gpcfg_top.
*/
module gpcfg_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial port
  input wire logic scl,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe,
  // sources and pins
  input wire logic output_data_bit_two,
  input wire logic free_clk_in,
  input wire logic link_tx_clk_in,
  input wire logic rec_clk_in,
  input wire logic [2:0] gp_pin_in,
  // pad control
  input wire logic gp2_out,
  input wire logic pin_driver_on,
  input wire logic gp2_in_buf_en,
  input wire logic gp2_pull_down,
  input wire logic gp2_pull_up
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] line_r, line_nxt;
  logic [4:0] rises_r, rises_nxt;
  wire any_src = output_data_bit_two | free_clk_in | link_tx_clk_in | rec_clk_in;
  // scl rises since the last start; saturates so long reads stay legal
  always_comb begin
    line_nxt = {scl, sda_i};
    rises_nxt = rises_r;
    if (line_r[0] && !sda_i && scl) rises_nxt = 5'h00;
    else if (!line_r[1] && scl && rises_r != 5'h1f) rises_nxt = rises_r + 5'h01;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_r <= 2'h3;
      rises_r <= 5'h00;
    end else begin
      line_r <= line_nxt;
      rises_r <= rises_nxt;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence bus_start;
    $fell(sda_i) && scl;
  endsequence
  pulls_exclusive_a: assert property (!(gp2_pull_down && gp2_pull_up))
    else $error("both resistors on");
  reset_pads_a: assert property ($rose(rst_n) |-> pin_driver_on && !gp2_in_buf_en && gp2_pull_down && !gp2_pull_up)
    else $error("pad reset state wrong");
  pads_after_bus_a: assert property ($changed({pin_driver_on, gp2_in_buf_en, gp2_pull_down, gp2_pull_up}) |-> !$past(scl, 4))
    else $error("pad control moved without a write");
  out_has_source_a: assert property (gp2_out |-> $past(any_src) || $past(any_src, 2))
    else $error("pin driven high with no source high");
  open_drain_a: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  ack_edge_a: assert property ($changed(sda_oe) |-> !scl)
    else $error("data line moved while scl high");
  start_quiet_a: assert property (bus_start |-> !sda_oe [*8])
    else $error("slave drove during start");
  ack_late_a: assert property ($rose(sda_oe) |-> rises_r >= 5'h08)
    else $error("slave drove before eight bits");
endmodule // gpcfg_assertions

bind gpcfg_top gpcfg_assertions chk (
  .clk(clk),
  .rst_n(rst_n),
  .scl(scl),
  .sda_i(sda_i),
  .sda_o(sda_o),
  .sda_oe(sda_oe),
  .output_data_bit_two(output_data_bit_two),
  .free_clk_in(free_clk_in),
  .link_tx_clk_in(link_tx_clk_in),
  .rec_clk_in(rec_clk_in),
  .gp_pin_in(gp_pin_in),
  .gp2_out(gp2_out),
  .pin_driver_on(pin_driver_on),
  .gp2_in_buf_en(gp2_in_buf_en),
  .gp2_pull_down(gp2_pull_down),
  .gp2_pull_up(gp2_pull_up)
);

// ===== tb/gpcfg_pin_model.sv
/*
  board logic on the three general-purpose pins.
  assumes pin 2 is shared with the block's driver and resistors.
*/
module gpcfg_pin_model (
  // from the block
  input wire logic gp2_out,
  input wire logic pin_driver_on,
  input wire logic gp2_pull_down,
  input wire logic gp2_pull_up,
  // bench commands
  input wire logic [2:0] ext_lvl,
  input wire logic ext_drive,
  // pin levels
  output logic [2:0] gp_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // board drives pin 2 only while the block floats it, so no contention
  wire ext2 = ext_drive && !pin_driver_on;
  always_comb begin
    gp_pin_in[1:0] = ext_lvl[1:0];
    if (pin_driver_on) gp_pin_in[2] = gp2_out;
    else if (ext2) gp_pin_in[2] = ext_lvl[2];
    else if (gp2_pull_up) gp_pin_in[2] = 1'b1;
    else if (gp2_pull_down) gp_pin_in[2] = 1'b0;
    else gp_pin_in[2] = ~ext_lvl[2];
  end
endmodule // gpcfg_pin_model

// ===== tb/test_gpio2_config_and_input.sv
/*
  bench for the pin-2 block: a two-wire master drives the registers.
  assumes the default slave address and a pulled-up data line.
*/
module test_gpio2_config_and_input;
  timeunit 1ns;
  timeprecision 1ns;
  import gpcfg_pkg::*;
  logic clk, rst_n, scl, m_sda, ext_drive, k;
  logic [3:0] srcs;
  logic [2:0] ext_lvl, gp_pin_in;
  logic [7:0] v, cfg;
  wire sda_o, sda_oe, gp2_out, pin_driver_on, gp2_in_buf_en, gp2_pull_down, gp2_pull_up;
  wire sda = sda_oe ? sda_o : m_sda;
  wire [7:0] pads = {4'h0, pin_driver_on, gp2_in_buf_en, gp2_pull_down, gp2_pull_up};
  int fails, tests_run, cyc;
  gpcfg_top dut (.clk(clk), .rst_n(rst_n), .scl(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .output_data_bit_two(srcs[0]), .free_clk_in(srcs[1]), .link_tx_clk_in(srcs[2]), .rec_clk_in(srcs[3]),
    .gp_pin_in(gp_pin_in), .gp2_out(gp2_out), .pin_driver_on(pin_driver_on), .gp2_in_buf_en(gp2_in_buf_en),
    .gp2_pull_down(gp2_pull_down), .gp2_pull_up(gp2_pull_up));
  gpcfg_pin_model board (.gp2_out(gp2_out), .pin_driver_on(pin_driver_on), .gp2_pull_down(gp2_pull_down),
    .gp2_pull_up(gp2_pull_up), .ext_lvl(ext_lvl), .ext_drive(ext_drive), .gp_pin_in(gp_pin_in));
  always #5 clk = ~clk;
  task automatic complete_run;
    if (fails == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      complete_run;
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hb;
    repeat (8) @(negedge clk);
  endtask
  // one bit: data set while scl low, sampled at the end of scl high, just before scl falls
  task automatic bit_x(input logic b, output logic s);
    m_sda = b;
    hb;
    scl = 1'b1;
    hb;
    s = sda;
    scl = 1'b0;
  endtask
  task automatic start;
    m_sda = 1'b1;
    hb;
    scl = 1'b1;
    hb;
    m_sda = 1'b0;
    hb;
    scl = 1'b0;
  endtask
  task automatic stop;
    m_sda = 1'b0;
    hb;
    scl = 1'b1;
    hb;
    m_sda = 1'b1;
    hb;
  endtask
  // writing ff releases the line, so the same task reads a byte and sends a nack
  task automatic xfer(input logic [7:0] w, output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) bit_x(w[i], r[i]);
    bit_x(1'b1, a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic [2:0] n;
    start;
    xfer({GPCFG_DEF_ADDR, 1'b0}, r, n[2]);
    xfer(a, r, n[1]);
    xfer(d, r, n[0]);
    stop;
    check("write ack", {5'h00, n}, 8'h00);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    logic [3:0] n;
    start;
    xfer({GPCFG_DEF_ADDR, 1'b0}, d, n[3]);
    xfer(a, d, n[2]);
    start;
    xfer({GPCFG_DEF_ADDR, 1'b1}, d, n[1]);
    xfer(8'hff, d, n[0]);
    stop;
    check("read ack", {4'h0, n}, 8'h01);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    scl = 1'b1;
    m_sda = 1'b1;
    srcs = 4'h0;
    ext_lvl = 3'h0;
    ext_drive = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    hb;
    check("pads reset", pads, 8'h0a);
    rd(GPCFG_OFS_CFG, v);
    check("cfg reset", v, GPCFG_CFG_RST);
    for (int i = 0; i < 5; i++) begin
      // driving the pin, so the input buffer stays off
      cfg = {i[3:0], i[1:0], 2'b01};
      wr(GPCFG_OFS_CFG, cfg);
      rd(GPCFG_OFS_CFG, v);
      check("cfg back", v, cfg);
      check("pads", pads, {6'h02, i[1:0] == 2'b01, i[1:0] == 2'b10});
      for (int p = 0; p < 2; p++) begin
        srcs = p ? 4'h5 : 4'ha;
        repeat (4) @(negedge clk);
        check("pin out", {7'h00, gp2_out}, {7'h00, i < 4 && srcs[i]});
      end
    end
    wr(GPCFG_OFS_CFG, 8'h0a);
    check("input pads", pads, 8'h05);
    ext_drive = 1'b1;
    for (int p = 0; p < 8; p++) begin
      ext_lvl = p[2:0];
      rd(GPCFG_OFS_LVL, v);
      check("levels", v, {5'h00, p[2:0]});
    end
    ext_lvl = 3'h2;
    wr(GPCFG_OFS_LVL, 8'hfd);
    rd(GPCFG_OFS_LVL, v);
    check("levels after write", v, 8'h02);
    wr(GPCFG_OFS_CFG, 8'h08);
    ext_lvl = 3'h7;
    rd(GPCFG_OFS_LVL, v);
    check("levels buffer off", v, 8'h03);
    rd(8'h07, v);
    check("unmapped", v, 8'h00);
    // a master acknowledge makes the slave send the same register again
    start;
    xfer({GPCFG_DEF_ADDR, 1'b0}, v, k);
    xfer(GPCFG_OFS_CFG, v, k);
    start;
    xfer({GPCFG_DEF_ADDR, 1'b1}, v, k);
    for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
    bit_x(1'b0, k);
    check("first of two", v, 8'h08);
    xfer(8'hff, v, k);
    stop;
    check("second of two", v, 8'h08);
    // later bytes of one write land on the same offset
    start;
    xfer({GPCFG_DEF_ADDR, 1'b0}, v, k);
    xfer(GPCFG_OFS_CFG, v, k);
    xfer(8'h18, v, k);
    xfer(8'h28, v, k);
    stop;
    rd(GPCFG_OFS_CFG, v);
    check("last byte kept", v, 8'h28);
    start;
    xfer({GPCFG_DEF_ADDR ^ 7'h01, 1'b0}, v, k);
    stop;
    check("foreign address", {7'h00, k}, 8'h01);
    complete_run;
  end
endmodule // test_gpio2_config_and_input
